// ==== clock_power_pkg.sv ====
package clock_power_pkg;

  // ------------------------------------------------------------
  // special function register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] power_key_addr         = 8'hc1;
  localparam logic [7:0] power_control_addr     = 8'hc5;
  localparam logic [7:0] measurement_start_addr = 8'hd8;
  localparam logic [7:0] peripheral_config_addr = 8'hf4;

  // ------------------------------------------------------------
  // field positions and values
  // ------------------------------------------------------------
  localparam logic [7:0] unlock_key            = 8'ha7;
  localparam int         core_shutdown_bit     = 4;
  localparam logic [2:0] divider_reset         = 3'h2;
  localparam int         receive_wake_bit      = 7;
  localparam int         rail_source_bit       = 6;
  localparam int         supply_ok_bit         = 5;
  localparam int         pll_unlock_bit        = 4;
  localparam int         ext_ref_bit           = 2;
  localparam int         fault_clear_bit       = 7;
  localparam int         supply_request_bit    = 2;
  localparam int         temp_request_bit      = 1;
  localparam int         battery_request_bit   = 0;
  localparam logic [1:0] rx_gpio               = 2'h0;
  localparam logic [1:0] rx_uart               = 2'h1;
  localparam logic [1:0] rx_uart_wake          = 2'h3;

  // ------------------------------------------------------------
  // clock figures
  // ------------------------------------------------------------
  localparam int         crystal_hz            = 32768;
  localparam int         pll_hz                = 4096000;
  localparam int         pll_multiple          = pll_hz / crystal_hz;
  localparam int         measure_divide        = 5;

endpackage

// ==== request_if.sv ====
`timescale 1ns/1ns
// one request and acknowledge pair toward the housekeeping converter
interface request_if;
  logic set;
  logic req;
  logic ack;
  modport owner (input set, input ack, output req);
  modport adc   (input req, output ack);
endinterface

// ==== request_slot.sv ====
`timescale 1ns/1ns
module request_slot (
  input  wire logic   clk,
  input  wire logic   reset_n,
  request_if.owner    port
);
  typedef struct packed {
    logic pending;
  } slot_s;

  slot_s state_reg;
  slot_s state_next;

  // ------------------------------------------------------------
  // request held until the converter acknowledges
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (port.ack) begin
      state_next.pending = 1'b0;
    end
    // a fresh write after the acknowledge keeps a new request alive
    if (port.set) begin
      state_next.pending = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.req = state_reg.pending;
endmodule

// ==== core_clock_power_config.sv ====
`timescale 1ns/1ns
// Operation
// - core clock equals pll over two-power divider
// - shutdown bit stops core in saving mode
// - key 0xa7 unlocks power control write
// - receive edge wake sets flag bit seven
// - bit six shows switched rail source
// - bit five shows main supply good
// - bit four shows pll unlocked
// - bit two selects external reference
// - fault clear bit seven clears unlock flag
// - fault flag held until software acknowledges
// - supply request bit self-clears on acceptance
// - temperature request bit self-clears on acceptance
// - battery request bit self-clears on acceptance
// - measurement clock fixed at pll over five
// - pll locks to crystal multiple
module core_clock_power_config
  import clock_power_pkg::*;
#(
  parameter int divider_width = 3
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       sfr_write,
  input  wire logic       sfr_read,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       pll_locked,
  input  wire logic       pll_loss_reset,
  input  wire logic       main_supply_ok,
  input  wire logic       rail_on_main,
  input  wire logic       rx_edge_wake,
  input  wire logic       battery_saving_mode_one,
  input  wire logic       supply_ack,
  input  wire logic       temp_ack,
  input  wire logic       battery_ack,
  output logic            supply_measure_request,
  output logic            temp_measure_request,
  output logic            battery_measure_request,
  output logic            pll_multiplier_valid,
  output logic            core_clock_enable,
  output logic            measure_clock_enable,
  output logic            core_halt,
  output logic            external_reference_enable,
  output logic            rx_uart_select,
  output logic            rx_wake_enable
);
  // the read-back packing and the divide table both assume a three-bit code,
  // so any other width is refused before the logic is built
  if (divider_width != 3) begin : g_width_check
    $error("divider field must be three bits");
  end

  typedef struct packed {
    logic [7:0] rdata;
    logic       key_open;
    logic       core_shutdown;
    logic [2:0] core_clock_divider;
    logic       receive_wake_flag;
    logic       switched_rail_source;
    logic       supply_good;
    logic       pll_unlock_flag;
    logic       ext_ref;
    logic [1:0] receive_pin_function;
    logic [6:0] core_count;
    logic [2:0] measure_count;
    logic       core_tick;
    logic       measure_tick;
  } ctrl_s;

  ctrl_s state_reg;
  ctrl_s state_next;

  request_if supply_if ();
  request_if temp_if ();
  request_if battery_if ();

  // ------------------------------------------------------------
  // per-source request slots
  // ------------------------------------------------------------
  logic wr_start;
  assign wr_start       = sfr_write && sfr_addr == measurement_start_addr;
  assign supply_if.set  = wr_start && sfr_wdata[supply_request_bit];
  assign temp_if.set    = wr_start && sfr_wdata[temp_request_bit];
  assign battery_if.set = wr_start && sfr_wdata[battery_request_bit];
  assign supply_if.ack  = supply_ack;
  assign temp_if.ack    = temp_ack;
  assign battery_if.ack = battery_ack;

  request_slot supply_slot (
    .clk     (clk),
    .reset_n (reset_n),
    .port    (supply_if.owner)
  );
  request_slot temp_slot (
    .clk     (clk),
    .reset_n (reset_n),
    .port    (temp_if.owner)
  );
  request_slot battery_slot (
    .clk     (clk),
    .reset_n (reset_n),
    .port    (battery_if.owner)
  );

  function automatic logic [6:0] divide_limit(input logic [2:0] code);
    divide_limit = 7'((8'h1 << code) - 8'h1);
  endfunction

  // ------------------------------------------------------------
  // register file, dividers and status capture
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.core_tick = 1'b0;
    state_next.measure_tick = 1'b0;
    // core clock enable: one pulse per two-power of pll cycles
    if (state_reg.core_count >= divide_limit(state_reg.core_clock_divider)) begin
      state_next.core_count = '0;
      state_next.core_tick = 1'b1;
    end else begin
      state_next.core_count = state_reg.core_count + 7'h1;
    end
    // measurement enable ignores the core divider entirely
    if (state_reg.measure_count == 3'(measure_divide - 1)) begin
      state_next.measure_count = '0;
      state_next.measure_tick = 1'b1;
    end else begin
      state_next.measure_count = state_reg.measure_count + 3'h1;
    end
    // live supply status
    state_next.switched_rail_source = rail_on_main;
    state_next.supply_good = main_supply_ok;
    // any sfr write other than the key closes the unlock window
    if (sfr_write) begin
      state_next.key_open = 1'b0;
      case (sfr_addr)
        power_key_addr: begin
          state_next.key_open = (sfr_wdata == unlock_key);
        end
        power_control_addr: begin
          if (state_reg.key_open) begin
            state_next.core_shutdown = sfr_wdata[core_shutdown_bit];
            state_next.core_clock_divider = sfr_wdata[2:0];
          end
        end
        peripheral_config_addr: begin
          state_next.ext_ref = sfr_wdata[ext_ref_bit];
          state_next.receive_pin_function = sfr_wdata[1:0];
          // software may clear the wake flag by writing zero
          if (!sfr_wdata[receive_wake_bit]) begin
            state_next.receive_wake_flag = 1'b0;
          end
        end
        measurement_start_addr: begin
          if (sfr_wdata[fault_clear_bit]) begin
            state_next.pll_unlock_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware events win over a same-cycle clear
    if (rx_edge_wake) begin
      state_next.receive_wake_flag = 1'b1;
    end
    if (pll_loss_reset || !pll_locked) begin
      state_next.pll_unlock_flag = 1'b1;
    end
    // registered read data
    case (sfr_addr)
      power_control_addr:
        state_next.rdata = {3'h0, state_reg.core_shutdown, 1'b0,
                            state_reg.core_clock_divider};
      peripheral_config_addr:
        state_next.rdata = {state_reg.receive_wake_flag, state_reg.switched_rail_source,
                            state_reg.supply_good, state_reg.pll_unlock_flag, 1'b0,
                            state_reg.ext_ref, state_reg.receive_pin_function};
      measurement_start_addr:
        state_next.rdata = {5'h0, supply_if.req, temp_if.req, battery_if.req};
      default:
        state_next.rdata = 8'h00; // key register is write only
    endcase
    if (!sfr_read) begin
      state_next.rdata = state_reg.rdata;
    end
  end

  // reset values: divider code two, rail source on main, all else clear;
  // a pll loss that caused the reset sets the unlock flag again at once,
  // since the loss input is sampled from the first edge after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.core_clock_divider <= divider_reset;
      state_reg.switched_rail_source <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sfr_rdata = state_reg.rdata;
  assign supply_measure_request = supply_if.req;
  assign temp_measure_request = temp_if.req;
  assign battery_measure_request = battery_if.req;
  // high only while the system rate is a whole multiple of the crystal
  assign pll_multiplier_valid = (pll_multiple * crystal_hz == pll_hz);
  assign core_clock_enable = state_reg.core_tick;
  assign measure_clock_enable = state_reg.measure_tick;
  assign core_halt = state_reg.core_shutdown && battery_saving_mode_one;
  assign external_reference_enable = state_reg.ext_ref;
  assign rx_uart_select = state_reg.receive_pin_function[0];
  assign rx_wake_enable = (state_reg.receive_pin_function == rx_uart_wake);
endmodule

// ==== cpc_assertions.sv ====
`timescale 1ns/1ns
// ------
// port checks
// ------
module cpc_assertions
  import clock_power_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sfr_write,
  input wire logic       sfr_read,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       pll_loss_reset,
  input wire logic       battery_saving_mode_one,
  input wire logic       supply_ack,
  input wire logic       temp_ack,
  input wire logic       battery_ack,
  input wire logic       supply_measure_request,
  input wire logic       temp_measure_request,
  input wire logic       battery_measure_request,
  input wire logic       pll_multiplier_valid,
  input wire logic       measure_clock_enable,
  input wire logic       core_halt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // a start write in the acknowledge cycle rightly keeps a request alive
  logic start_wr;
  assign start_wr = sfr_write && sfr_addr == measurement_start_addr;
  // halt follows the mode, and only a control write can raise it alone
  a_halt_needs_mode: assert property (core_halt |-> battery_saving_mode_one)
    else $error("core halted outside saving mode");
  a_halt_from_write: assert property ($rose(core_halt) &&
    $stable(battery_saving_mode_one) |-> $past(sfr_write) &&
    $past(sfr_addr) == power_control_addr) else $error("core halted without a control write");
  // requests stand until taken, then fall at once
  a_supply_req_holds: assert property (supply_measure_request && !supply_ack |=>
    supply_measure_request) else $error("supply request dropped early");
  a_supply_req_drops: assert property (supply_measure_request && supply_ack &&
    !(start_wr && sfr_wdata[supply_request_bit]) |=> !supply_measure_request)
    else $error("supply request kept after ack");
  a_temp_req_drops: assert property (temp_measure_request && temp_ack &&
    !(start_wr && sfr_wdata[temp_request_bit]) |=> !temp_measure_request)
    else $error("temp request kept after ack");
  a_batt_req_drops: assert property (battery_measure_request && battery_ack &&
    !(start_wr && sfr_wdata[battery_request_bit]) |=> !battery_measure_request)
    else $error("battery request kept after ack");
  // status reads: key reads back empty, fault shows one cycle after the loss
  a_key_reads_zero: assert property (sfr_read && sfr_addr == power_key_addr |=>
    sfr_rdata == 8'h00) else $error("key register read not zero");
  a_fault_reads_set: assert property (pll_loss_reset ##1
    (sfr_read && sfr_addr == peripheral_config_addr) |=> sfr_rdata[pll_unlock_bit])
    else $error("fault flag missing");
  // measure clock keeps one pulse in five whatever the divider
  a_measure_period: assert property (measure_clock_enable |=>
    !measure_clock_enable [*4] ##1 measure_clock_enable) else $error("measure period");
  a_mult_valid: assert property (pll_multiplier_valid)
    else $error("multiplier not valid");
  c_request_taken: cover property (supply_measure_request && supply_ack);
  c_core_halt: cover property (core_halt);
  c_fault_read: cover property (pll_loss_reset ##1 sfr_read);
endmodule

bind core_clock_power_config cpc_assertions i_cpc_assertions (.*);

// ==== adc_model.sv ====
`timescale 1ns/1ns
// ------
// housekeeping converter, one-cycle acknowledge
// ------
module adc_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       slow,
  input  wire logic [2:0] req,
  output logic      [2:0] ack
);
  logic [2:0] wait_cnt [3];
  // each source answers on its own; slow mode stalls four cycles
  always @(posedge clk or negedge reset_n) begin
    for (int i = 0; i < 3; i++) begin
      if (!reset_n) begin
        ack[i] <= 1'b0;
        wait_cnt[i] <= 3'h0;
      end else begin
        ack[i] <= req[i] && !ack[i] && wait_cnt[i] == (slow ? 3'h4 : 3'h0);
        wait_cnt[i] <= (req[i] && !ack[i]) ? wait_cnt[i] + 3'h1 : 3'h0;
      end
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  import clock_power_pkg::*;
  logic       clk, reset_n, sfr_write, sfr_read, pll_locked, pll_loss_reset, slow;
  logic       main_supply_ok, rail_on_main, rx_edge_wake, battery_saving_mode_one;
  logic       supply_ack, temp_ack, battery_ack, pll_multiplier_valid, core_halt;
  logic       supply_measure_request, temp_measure_request, battery_measure_request;
  logic       core_clock_enable, measure_clock_enable, external_reference_enable;
  logic       rx_uart_select, rx_wake_enable;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int         n_mismatch, n_compared;

  core_clock_power_config i_core_clock_power_config (.*);
  adc_model i_adc_model (.clk, .reset_n, .slow,
    .req({supply_measure_request, temp_measure_request, battery_measure_request}),
    .ack({supply_ack, temp_ack, battery_ack}));

  // free-running system clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask

  // strobe held through the taking edge, dropped a half cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_write = 1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_write = 0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] want);
    @(negedge clk);
    sfr_read = 1;
    sfr_addr = a;
    @(negedge clk);
    sfr_read = 0;
    @(negedge clk);
    check(sfr_rdata, want);
  endtask

  // skips one pulse so a divider change in flight cannot skew the count
  // measure picks the energy clock pulse instead of the core one
  task automatic period(input int want, input logic measure);
    int n;
    repeat (2) begin
      @(negedge clk);
      while ((measure ? measure_clock_enable : core_clock_enable) !== 1'b1) @(negedge clk);
    end
    n = 1;
    @(negedge clk);
    while ((measure ? measure_clock_enable : core_clock_enable) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'(want));
  endtask

  // key gating, shutdown in saving mode, and the divider end codes
  task automatic t_key;
    wr(8'hc5, 8'h13);
    rchk(8'hc5, 8'h02);
    wr(8'hc1, 8'ha7);
    wr(8'hd8, 8'h00);
    wr(8'hc5, 8'h13);
    rchk(8'hc5, 8'h02);
    check(core_halt, 1'b0);
    battery_saving_mode_one = 1;
    wr(8'hc1, 8'ha7);
    wr(8'hc5, 8'h13);
    check(core_halt, 1'b1);
    rchk(8'hc5, 8'h13);
    period(8, 1'b0);
    period(5, 1'b1);
    battery_saving_mode_one = 0;
    @(negedge clk);
    check(core_halt, 1'b0);
    battery_saving_mode_one = 1;
    wr(8'hc5, 8'h02);
    rchk(8'hc5, 8'h13);
    wr(8'hc1, 8'ha7);
    wr(8'hc5, 8'h02);
    check(core_halt, 1'b0);
    battery_saving_mode_one = 0;
    wr(8'hc1, 8'ha7);
    wr(8'hc5, 8'h07);
    period(128, 1'b0);
    wr(8'hc1, 8'ha7);
    wr(8'hc5, 8'h00);
    period(1, 1'b0);
  endtask

  task automatic t_status;
    logic [1:0] f [3] = '{rx_gpio, rx_uart, rx_uart_wake};
    main_supply_ok = 1;
    rail_on_main = 0;
    rx_edge_wake = 1;
    rx_edge_wake <= #50 1'b0;
    rchk(8'hf4, 8'ha0);
    wr(8'hf4, 8'h07);
    rchk(8'hf4, 8'h27);
    check(external_reference_enable, 1'b1);
    foreach (f[i]) begin
      wr(8'hf4, {6'h00, f[i]});
      check({rx_uart_select, rx_wake_enable}, {f[i] != 2'h0, f[i] == 2'h3});
    end
    check(external_reference_enable, 1'b0);
    rail_on_main = 1;
  endtask

  task automatic t_fault;
    pll_loss_reset = 1;
    pll_loss_reset <= #50 1'b0;
    // receive pin field is still 11 from the status scenario
    rchk(8'hf4, 8'h73);
    wr(8'hd8, 8'h80);
    rchk(8'hf4, 8'h63);
    pll_locked = 0;
    rchk(8'hf4, 8'h73);
    pll_locked = 1;
    wr(8'hd8, 8'h80);
    rchk(8'hf4, 8'h63);
  endtask

  task automatic t_request;
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      wr(8'hd8, 8'h07);
      check({supply_measure_request, temp_measure_request, battery_measure_request},
            3'h7);
      repeat (2 + s) @(negedge clk);
      check({supply_measure_request, temp_measure_request, battery_measure_request},
            s ? 3'h7 : 3'h0);
      repeat (6) @(negedge clk);
      rchk(8'hd8, 8'h00);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reset, then each scenario in turn
  initial begin
    {reset_n, sfr_write, sfr_read, pll_loss_reset, rx_edge_wake, slow} = 6'h00;
    {main_supply_ok, battery_saving_mode_one, pll_locked, rail_on_main} = 4'h3;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    n_mismatch = 0;
    n_compared = 0;
    // count rising edges: the clock's first step at time zero is a falling one
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1;
    rchk(8'hc5, 8'h02);
    rchk(8'hf4, 8'h40);
    rchk(8'hc1, 8'h00);
    check(pll_multiplier_valid, 1'b1);
    period(4, 1'b0);
    period(5, 1'b1);
    t_key();
    t_status();
    t_fault();
    t_request();
    stop_test();
  end

  // hang guard, far beyond the few hundred cycles the scenarios need
  initial begin
    #200us;
    n_mismatch++;
    stop_test();
  end
endmodule
